/* File: verilog/io_register_space_decoder.sv */
`timescale 1ns/1ns
module io_register_space_decoder (
	input  wire logic                  CLK_SYS_IN,   // 100 MHz core clock
	input  wire logic                  RESETN_IN,    // async reset, active low
	input  wire io_space_pkg::access_t ACC_KIND_IN,  // access kind, one cycle
	input  wire logic [7:0]            ACC_ADDR_IN,  // I/O or data address
	input  wire logic [2:0]            ACC_BIT_IN,   // bit number for bit ops
	input  wire logic [7:0]            ACC_WDATA_IN, // write data
	input  wire logic [7:0]            FLAG_SET_IN,  // hardware flag events, indexed below
	output logic      [7:0]            RDATA_OUT,    // read data
	output logic                       SKIP_OUT,     // bit test says skip
	output logic                       ACK_OUT,      // access answered
	output logic      [8:0]            NVM_ADDR_OUT  // effective nvm address
);
	import io_space_pkg::*;

	typedef struct packed {
		logic [NUM_REGS-1:0][7:0] regs;
		logic [7:0] rdata;
		logic       skip;
		logic       ack;
	} state_t;

	state_t st_r;
	state_t st_nxt;
	logic [7:0] daddr;
	logic       legal;
	logic [7:0] onehot;

	io_addr_decode u_dec (
		.kind_in   (ACC_KIND_IN),
		.addr_in   (ACC_ADDR_IN),
		.bit_in    (ACC_BIT_IN),
		.daddr_out (daddr),
		.legal_out (legal),
		.onehot_out(onehot)
	);

	// Returns register index, or NUM_REGS when the address is reserved.
	function automatic int reg_index(input logic [7:0] a);
		int idx;
		idx = NUM_REGS;
		if (a == A_EXT_INT_MASK) idx = 0;
		else if (a == A_GP0) idx = 1;
		else if (a == A_NVM_CTRL) idx = 2;
		else if (a == A_NVM_DATA) idx = 3;
		else if (a == A_NVM_ADDR_LO) idx = 4;
		else if (a == A_NVM_ADDR_HI) idx = 5;
		else if (a == A_TMR_GLOBAL) idx = 6;
		else if (a == A_TMR0_CTRL_A) idx = 7;
		else if (a == A_TMR0_CTRL_B) idx = 8;
		else if (a == A_TMR0_COUNT) idx = 9;
		else if (a == A_TMR0_CMP_A) idx = 10;
		else if (a == A_GP1) idx = 11;
		else if (a == A_GP2) idx = 12;
		else if (a == A_SPI_CTRL) idx = 13;
		else if (a == A_SPI_STATUS) idx = 14;
		else if (a == A_SPI_DATA) idx = 15;
		else if (a == A_CMP_CTRL) idx = 16;
		else if (a == A_DBG_DATA) idx = 17;
		else if (a == A_SLEEP_CTRL) idx = 18;
		else if (a == A_RESET_CAUSE) idx = 19;
		else if (a == A_CORE_CTRL) idx = 20;
		else if (a == A_SELF_PROG) idx = 21;
		else if (a == A_SP_LOW) idx = 22;
		else if (a == A_SP_HIGH) idx = 23;
		else if (a == A_CPU_FLAGS) idx = 24;
		else if (a == A_WDOG_CTRL) idx = 25;
		return idx;
	endfunction : reg_index

	// Implemented bits of each register; reserved bits hold zero.
	function automatic logic [7:0] impl_mask(input int idx);
		logic [7:0] m;
		m = 8'hff;
		if (idx == 0) m = M_EXT_INT_MASK;
		else if (idx == 2) m = M_NVM_CTRL;
		else if (idx == 5) m = M_NVM_ADDR_HI;
		else if (idx == 6) m = M_TMR_GLOBAL;
		else if (idx == 7) m = M_TMR0_CTRL_A;
		else if (idx == 8) m = M_TMR0_CTRL_B;
		else if (idx == 14) m = M_SPI_STATUS;
		else if (idx == 18) m = M_SLEEP_CTRL;
		else if (idx == 19) m = M_RESET_CAUSE;
		else if (idx == 20) m = M_CORE_CTRL;
		else if (idx == 21) m = M_SELF_PROG;
		else if (idx >= NUM_REGS) m = 8'h00;
		return m;
	endfunction : impl_mask

	function automatic logic [7:0] w1c_mask(input int idx);
		logic [7:0] m;
		m = 8'h00;
		if (idx == 16) m = W1C_CMP_CTRL;
		else if (idx == 19) m = W1C_RESET_CAUSE;
		else if (idx == 25) m = W1C_WDOG_CTRL;
		return m;
	endfunction : w1c_mask

	always_comb begin
		int idx;
		logic [7:0] cur;
		logic [7:0] msk;
		logic [7:0] w1c;
		logic [7:0] wv;
		logic       do_wr;
		idx    = reg_index(daddr);
		st_nxt = st_r;
		st_nxt.ack  = ACC_KIND_IN != ACC_NONE;
		st_nxt.skip = 1'b0;
		msk   = impl_mask(idx);
		w1c   = w1c_mask(idx);
		cur   = (idx < NUM_REGS) ? st_r.regs[idx] : 8'h00;
		wv    = cur;
		do_wr = 1'b0;
		st_nxt.rdata = 8'h00;
		if (legal && idx < NUM_REGS) begin
			case (ACC_KIND_IN)
				ACC_IO_RD, ACC_LOAD: st_nxt.rdata = cur & msk;
				ACC_TEST: st_nxt.skip = |(cur & onehot);
				ACC_SET: begin
					// Flags of other bits keep their value; a set never clears a flag.
					wv    = cur | (onehot & ~w1c);
					do_wr = 1'b1;
				end
				ACC_CLR: begin
					wv    = cur & ~onehot;
					wv    = (wv & ~w1c) | (cur & w1c);
					do_wr = 1'b1;
				end
				ACC_IO_WR, ACC_STORE: begin
					// Write one clears a flag, zero leaves it.
					wv    = (ACC_WDATA_IN & ~w1c) | (cur & w1c & ~ACC_WDATA_IN);
					do_wr = 1'b1;
				end
				default: do_wr = 1'b0;
			endcase
		end
		// Reserved bits never take a write.
		if (do_wr) begin
			st_nxt.regs[idx] = wv & msk;
		end
		// Hardware flag events win over a clear in the same cycle.
		st_nxt.regs[16] = st_nxt.regs[16] | (FLAG_SET_IN[0] ? W1C_CMP_CTRL : 8'h00);
		st_nxt.regs[25] = st_nxt.regs[25] | (FLAG_SET_IN[1] ? W1C_WDOG_CTRL : 8'h00);
		st_nxt.regs[19] = st_nxt.regs[19] | ({4'h0, FLAG_SET_IN[5:2]} & W1C_RESET_CAUSE);
	end

	always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign RDATA_OUT = st_r.rdata;
	assign SKIP_OUT  = st_r.skip;
	assign ACK_OUT   = st_r.ack;
	// Bits above the top implemented address bit are dropped.
	assign NVM_ADDR_OUT = {st_r.regs[5][NVM_ADDR_TOP_BIT-8], st_r.regs[4]};
endmodule : io_register_space_decoder

/* File: verilog/io_space_pkg.sv */
package io_space_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int IO_ADDR_W = 6;
	localparam logic [7:0] DATA_SPACE_OFFSET = 8'h20;
	localparam logic [7:0] BIT_IO_LAST       = 8'h1f;
	localparam logic [7:0] IO_LAST           = 8'h3f;
	localparam logic [7:0] EXT_FIRST         = 8'h60;
	localparam int NVM_ADDR_TOP_BIT = 8;

	// Access kinds issued by the core.
	typedef enum logic [2:0] {
		ACC_NONE   = 3'h0,
		ACC_IO_RD  = 3'h1,
		ACC_IO_WR  = 3'h2,
		ACC_SET    = 3'h3,
		ACC_CLR    = 3'h4,
		ACC_TEST   = 3'h5,
		ACC_LOAD   = 3'h6,
		ACC_STORE  = 3'h7
	} access_t;

	// Data-space addresses of the implemented registers.
	localparam logic [7:0] A_EXT_INT_MASK  = 8'h3d;
	localparam logic [7:0] A_GP0           = 8'h3e;
	localparam logic [7:0] A_NVM_CTRL      = 8'h3f;
	localparam logic [7:0] A_NVM_DATA      = 8'h40;
	localparam logic [7:0] A_NVM_ADDR_LO   = 8'h41;
	localparam logic [7:0] A_NVM_ADDR_HI   = 8'h42;
	localparam logic [7:0] A_TMR_GLOBAL    = 8'h43;
	localparam logic [7:0] A_TMR0_CTRL_A   = 8'h45;
	localparam logic [7:0] A_TMR0_CTRL_B   = 8'h46;
	localparam logic [7:0] A_TMR0_COUNT    = 8'h47;
	localparam logic [7:0] A_TMR0_CMP_A    = 8'h48;
	localparam logic [7:0] A_GP1           = 8'h4a;
	localparam logic [7:0] A_GP2           = 8'h4b;
	localparam logic [7:0] A_SPI_CTRL      = 8'h4c;
	localparam logic [7:0] A_SPI_STATUS    = 8'h4d;
	localparam logic [7:0] A_SPI_DATA      = 8'h4e;
	localparam logic [7:0] A_CMP_CTRL      = 8'h50;
	localparam logic [7:0] A_DBG_DATA      = 8'h51;
	localparam logic [7:0] A_SLEEP_CTRL    = 8'h53;
	localparam logic [7:0] A_RESET_CAUSE   = 8'h54;
	localparam logic [7:0] A_CORE_CTRL     = 8'h55;
	localparam logic [7:0] A_SELF_PROG     = 8'h57;
	localparam logic [7:0] A_SP_LOW        = 8'h5d;
	localparam logic [7:0] A_SP_HIGH       = 8'h5e;
	localparam logic [7:0] A_CPU_FLAGS     = 8'h5f;
	localparam logic [7:0] A_WDOG_CTRL     = 8'h60;

	// Implemented-bit masks; zero bits are reserved.
	localparam logic [7:0] M_EXT_INT_MASK = 8'h03;
	localparam logic [7:0] M_NVM_CTRL     = 8'h3f;
	localparam logic [7:0] M_NVM_ADDR_HI  = 8'h01;
	localparam logic [7:0] M_TMR_GLOBAL   = 8'h83;
	localparam logic [7:0] M_TMR0_CTRL_A  = 8'hc3;
	localparam logic [7:0] M_TMR0_CTRL_B  = 8'h87;
	localparam logic [7:0] M_SPI_STATUS   = 8'hc1;
	localparam logic [7:0] M_CORE_CTRL    = 8'h70;
	localparam logic [7:0] M_RESET_CAUSE  = 8'h0f;
	localparam logic [7:0] M_SLEEP_CTRL   = 8'h07;
	localparam logic [7:0] M_SELF_PROG    = 8'h7f;
	// Flags cleared by writing one.
	localparam logic [7:0] W1C_CMP_CTRL   = 8'h10;
	localparam logic [7:0] W1C_WDOG_CTRL  = 8'h80;
	localparam logic [7:0] W1C_RESET_CAUSE = 8'h0f;
	localparam logic [7:0] RESET_VAL      = 8'h00;
	localparam int NUM_REGS = 26;
endpackage : io_space_pkg

/* File: verilog/io_addr_decode.sv */
`timescale 1ns/1ns
// Maps a core access to a data-space address and judges its legality.
module io_addr_decode
	import io_space_pkg::*;
(
	input  wire io_space_pkg::access_t kind_in,   // access kind
	input  wire logic [7:0]            addr_in,   // I/O or data address
	input  wire logic [2:0]            bit_in,    // bit number
	output logic       [7:0]           daddr_out, // data-space address
	output logic                       legal_out, // access allowed
	output logic       [7:0]           onehot_out // bit mask
);
	always_comb begin
		daddr_out  = addr_in;
		legal_out  = 1'b0;
		onehot_out = 8'h01 << bit_in;
		case (kind_in)
			ACC_IO_RD, ACC_IO_WR: begin
				// Only six address bits exist in the opcode field.
				daddr_out = {2'b00, addr_in[IO_ADDR_W-1:0]} + DATA_SPACE_OFFSET;
				legal_out = addr_in <= IO_LAST;
			end
			ACC_SET, ACC_CLR, ACC_TEST: begin
				daddr_out = addr_in + DATA_SPACE_OFFSET;
				legal_out = addr_in <= BIT_IO_LAST;
			end
			ACC_LOAD, ACC_STORE: begin
				legal_out = addr_in >= DATA_SPACE_OFFSET;
			end
			default: legal_out = 1'b0;
		endcase
	end
endmodule : io_addr_decode

/* File: verification/io_space_assertions.sv */
`timescale 1ns/1ns
module io_space_assertions
	import io_space_pkg::*;
(
	input wire logic                  CLK_SYS_IN,   // clock
	input wire logic                  RESETN_IN,    // reset
	input wire io_space_pkg::access_t ACC_KIND_IN,  // kind
	input wire logic [7:0]            ACC_ADDR_IN,  // address
	input wire logic [7:0]            ACC_WDATA_IN, // data
	input wire logic [7:0]            RDATA_OUT,    // read data
	input wire logic                  SKIP_OUT,     // skip
	input wire logic                  ACK_OUT,      // answer
	input wire logic [8:0]            NVM_ADDR_OUT  // nvm address
);
	default clocking @(posedge CLK_SYS_IN);
	endclocking
	default disable iff (!RESETN_IN);
	ack_one_cycle_a: assert property (ACC_KIND_IN != ACC_NONE |=> ACK_OUT)
		else $error("access not answered next cycle");
	ack_idle_a: assert property (ACC_KIND_IN == ACC_NONE |=> !ACK_OUT)
		else $error("answer without access");
	rdata_quiet_a: assert property (!ACK_OUT |-> RDATA_OUT == 8'h00)
		else $error("read data outside answer");
	skip_cause_a: assert property (SKIP_OUT |-> $past(ACC_KIND_IN) == ACC_TEST)
		else $error("skip without bit test");
	bit_range_a: assert property (ACC_KIND_IN == ACC_TEST && ACC_ADDR_IN > BIT_IO_LAST
		|=> !SKIP_OUT) else $error("bit test above bit range");
	io_range_a: assert property (ACC_KIND_IN == ACC_IO_RD && ACC_ADDR_IN > IO_LAST
		|=> RDATA_OUT == 8'h00) else $error("io read beyond 64 locations");
	load_low_a: assert property (ACC_KIND_IN == ACC_LOAD
		&& ACC_ADDR_IN < DATA_SPACE_OFFSET |=> RDATA_OUT == 8'h00)
		else $error("load below io mirror");
	mask_read_a: assert property (ACC_KIND_IN == ACC_LOAD && ACC_ADDR_IN == A_EXT_INT_MASK
		|=> (RDATA_OUT & ~M_EXT_INT_MASK) == 8'h00) else $error("reserved bits read");
	nvm_low_a: assert property (ACC_KIND_IN == ACC_STORE && ACC_ADDR_IN == A_NVM_ADDR_LO
		|=> NVM_ADDR_OUT[7:0] == $past(ACC_WDATA_IN)) else $error("nvm address low");
endmodule : io_space_assertions

/* File: verification/core_model.sv */
`timescale 1ns/1ns
// Issues one access per call and takes the answer 1 ns after the edge at which it is taken.
module core_model
	import io_space_pkg::*;
(
	input  wire logic       clk_in,   // core clock
	input  wire logic [7:0] rdata_in, // read data
	input  wire logic       skip_in,  // test result
	input  wire logic       ack_in,   // answer
	output access_t         kind_out, // access kind
	output logic      [7:0] addr_out, // address
	output logic      [2:0] bit_out,  // bit number
	output logic      [7:0] wdata_out // write data
);
	initial begin
		kind_out = ACC_NONE;
		addr_out = 8'h00;
		bit_out = 3'h0;
		wdata_out = 8'h00;
	end
	task automatic acc(access_t k, logic [7:0] a, logic [2:0] b, logic [7:0] d,
		output logic [7:0] q, output logic s, output logic g);
		@(posedge clk_in);
		kind_out <= k;
		addr_out <= a;
		bit_out <= b;
		wdata_out <= d;
		@(posedge clk_in);
		kind_out <= ACC_NONE;
		#1;
		q = rdata_in;
		s = skip_in;
		g = ack_in;
	endtask : acc
endmodule : core_model

/* File: verification/tb.sv */
`timescale 1ns/1ns
`define CHK(n, e, v) begin tests_run++; if ((v) !== (e)) begin errors++; \
	$display("MISMATCH %s exp %h got %h", n, e, v); end end
module tb;
	import io_space_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] flags = 8'h00;
	logic [7:0] rdata, q;
	logic [8:0] nvm;
	logic skip, ack, s, g;
	logic [7:0] addr, wdata;
	logic [2:0] bitn;
	access_t kind;
	int errors = 0;
	int tests_run = 0;
	always #5 clk = ~clk;
	io_register_space_decoder DUT (.CLK_SYS_IN(clk), .RESETN_IN(resetn), .ACC_KIND_IN(kind),
		.ACC_ADDR_IN(addr), .ACC_BIT_IN(bitn), .ACC_WDATA_IN(wdata), .FLAG_SET_IN(flags),
		.RDATA_OUT(rdata), .SKIP_OUT(skip), .ACK_OUT(ack), .NVM_ADDR_OUT(nvm));
	core_model core (.clk_in(clk), .rdata_in(rdata), .skip_in(skip), .ack_in(ack),
		.kind_out(kind), .addr_out(addr), .bit_out(bitn), .wdata_out(wdata));
	task automatic go(access_t k, logic [7:0] a, logic [2:0] b, logic [7:0] d);
		core.acc(k, a, b, d, q, s, g);
		`CHK("ack", 1'b1, g);
	endtask : go
	task automatic rd(access_t k, logic [7:0] a, logic [7:0] e);
		go(k, a, 3'h0, 8'h00);
		`CHK("rdata", e, q);
	endtask : rd
	task automatic summarize;
		if (errors == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : summarize
	initial begin
		repeat (2) @(posedge clk);
		`CHK("nvm", 9'h000, nvm);
		resetn <= 1'b1;
		go(ACC_IO_WR, 8'h1e, 3'h0, 8'ha5);
		rd(ACC_LOAD, 8'h3e, 8'ha5);
		go(ACC_SET, 8'h1e, 3'h1, 8'h00);
		go(ACC_CLR, 8'h1e, 3'h7, 8'h00);
		rd(ACC_IO_RD, 8'h1e, 8'h27);
		go(ACC_TEST, 8'h1e, 3'h0, 8'h00);
		`CHK("skip", 1'b1, s);
		go(ACC_TEST, 8'h1e, 3'h3, 8'h00);
		`CHK("skip", 1'b0, s);
		go(ACC_IO_WR, 8'h3e, 3'h0, 8'h01);
		go(ACC_SET, 8'h3e, 3'h1, 8'h00);
		go(ACC_CLR, 8'h3e, 3'h0, 8'h00);
		rd(ACC_IO_RD, 8'h3e, 8'h01);
		go(ACC_TEST, 8'h3e, 3'h0, 8'h00);
		`CHK("skip", 1'b0, s);
		go(ACC_IO_WR, 8'h40, 3'h0, 8'h7f);
		rd(ACC_LOAD, 8'h60, 8'h00);
		rd(ACC_IO_RD, 8'h40, 8'h00);
		rd(ACC_LOAD, 8'h1e, 8'h00);
		go(ACC_STORE, 8'h49, 3'h0, 8'hff);
		rd(ACC_LOAD, 8'h49, 8'h00);
		go(ACC_STORE, A_EXT_INT_MASK, 3'h0, 8'hff);
		rd(ACC_LOAD, A_EXT_INT_MASK, M_EXT_INT_MASK);
		go(ACC_STORE, A_NVM_ADDR_HI, 3'h0, 8'hff);
		go(ACC_STORE, A_NVM_ADDR_LO, 3'h0, 8'h5a);
		`CHK("nvm", 9'h15a, nvm);
		rd(ACC_LOAD, A_NVM_ADDR_HI, 8'h01);
		go(ACC_STORE, A_SLEEP_CTRL, 3'h0, 8'h05);
		rd(ACC_LOAD, A_SLEEP_CTRL, 8'h05);
		@(posedge clk);
		flags <= 8'h02;
		@(posedge clk);
		flags <= 8'h00;
		rd(ACC_LOAD, A_WDOG_CTRL, 8'h80);
		go(ACC_STORE, A_WDOG_CTRL, 3'h0, 8'h00);
		rd(ACC_LOAD, A_WDOG_CTRL, 8'h80);
		go(ACC_STORE, A_WDOG_CTRL, 3'h0, 8'h80);
		rd(ACC_LOAD, A_WDOG_CTRL, 8'h00);
		// A flag event in the cycle of its clear must win.
		fork
			go(ACC_STORE, A_WDOG_CTRL, 3'h0, 8'h80);
			begin
				@(posedge clk);
				flags <= 8'h02;
				@(posedge clk);
				flags <= 8'h00;
			end
		join
		rd(ACC_LOAD, A_WDOG_CTRL, 8'h80);
		summarize();
	end
endmodule : tb
bind io_register_space_decoder io_space_assertions chk (.CLK_SYS_IN, .RESETN_IN,
	.ACC_KIND_IN, .ACC_ADDR_IN, .ACC_WDATA_IN, .RDATA_OUT, .SKIP_OUT, .ACK_OUT,
	.NVM_ADDR_OUT);
